// ==== design/fesr_top.sv ====
// Erase suspend and resume sequencer behind a four-wire SPI link
`timescale 1ns/1ps
`include "fesr_params.svh"
module fesr_top #(
  parameter int SUSP_LAT_NS = `FESR_SUSP_LAT_NS
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic core_erase_busy,
  input wire logic core_prog_busy,
  input wire logic core_wrsr_busy,
  input wire logic core_wel_clr,
  input wire logic [1:0] core_erase_size,
  input wire logic [23:0] core_erase_addr,
  output logic spi_miso_r,
  output logic spi_miso_oe_r,
  output logic grant_valid_r,
  output logic [7:0] grant_opcode_r,
  output logic [23:0] grant_addr_r,
  output logic ignored_r,
  output logic erase_hold_r,
  output logic [15:0] status_word_r
);
  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int SUSP_LAT_RAW = (SUSP_LAT_NS * `FESR_CLK_MHZ + 999) / 1000;
  localparam int SUSP_LAT_CYC = (SUSP_LAT_RAW < 1) ? 1 : SUSP_LAT_RAW;
  localparam logic [15:0] SUSP_LAT_LD = 16'(SUSP_LAT_CYC - 1);
  localparam int RES_WIP_RAW = (`FESR_RES_WIP_NS * `FESR_CLK_MHZ) / 1000;
  localparam int RES_WIP_CYC = (RES_WIP_RAW < 1) ? 1 : RES_WIP_RAW;
  localparam int RES_WIP_LIM = RES_WIP_CYC - 1;

  function automatic logic region_hit(input logic [23:0] a, input logic [23:0] base,
                                      input fesr_pkg::fesr_esize_t sz);
    logic hit;
    hit = 1'b0;
    unique case (sz)
      fesr_pkg::FESR_ES_4K: hit = (a[23:12] == base[23:12]);
      fesr_pkg::FESR_ES_32K: hit = (a[23:15] == base[23:15]);
      fesr_pkg::FESR_ES_64K: hit = (a[23:16] == base[23:16]);
      // Unknown size code: guard the widest region rather than none
      default: hit = (a[23:16] == base[23:16]);
    endcase
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // Link sampling
  // ----------------------------------------------------------------
  // Link pins are asynchronous; edges are found only on the second and third stages
  logic [2:0] sclk_s_r;
  logic [2:0] cs_s_r;
  logic [1:0] mosi_s_r;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sclk_s_r <= 3'h0;
      cs_s_r <= 3'h7;
      mosi_s_r <= 2'h0;
    end else begin
      sclk_s_r <= {sclk_s_r[1:0], spi_sclk};
      cs_s_r <= {cs_s_r[1:0], spi_cs_n};
      mosi_s_r <= {mosi_s_r[0], spi_mosi};
    end
  end
  wire active_w = ~cs_s_r[1];
  wire sclk_rise_w = active_w & sclk_s_r[1] & ~sclk_s_r[2];
  wire sclk_fall_w = active_w & ~sclk_s_r[1] & sclk_s_r[2];
  wire cs_rise_w = cs_s_r[1] & ~cs_s_r[2];

  // ----------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------
  logic [5:0] bit_cnt_r;
  logic [31:0] rx_r;
  logic [7:0] opcode_r;
  logic [7:0] tx_r;
  wire [31:0] rx_nxt = {rx_r[30:0], mosi_s_r[1]};
  wire [23:0] addr_w = rx_nxt[23:0];
  wire op_done_w = sclk_rise_w & (bit_cnt_r == (`FESR_OP_BITS - 6'h01));
  wire addr_done_w = sclk_rise_w & (bit_cnt_r == (`FESR_ADDR_END - 6'h01));
  wire [7:0] op_nxt = rx_nxt[7:0];
  wire st_rd1_w = (op_nxt == `FESR_OP_RDSR1);
  wire st_rd2_w = (op_nxt == `FESR_OP_RDSR2);
  wire st_rd_w = st_rd1_w | st_rd2_w | (op_nxt == `FESR_OP_RDSR3);
  wire [7:0] st_byte_w = st_rd1_w ? status_word_r[7:0] :
                         st_rd2_w ? status_word_r[15:8] : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (!rstn || !active_w) begin
      bit_cnt_r <= 6'h00;
    end else if (sclk_rise_w && bit_cnt_r != 6'h3f) begin
      bit_cnt_r <= bit_cnt_r + 6'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rx_r <= 32'h0;
      opcode_r <= 8'h00;
    end else if (sclk_rise_w) begin
      rx_r <= rx_nxt;
      if (op_done_w) begin
        opcode_r <= op_nxt;
      end
    end
  end

  // Status byte repeats while the host keeps clocking; it is a snapshot taken at the opcode
  always_ff @(posedge ref_clk) begin
    if (!rstn || !active_w) begin
      tx_r <= 8'h00;
      spi_miso_r <= 1'b0;
      spi_miso_oe_r <= 1'b0;
    end else if (op_done_w) begin
      tx_r <= st_byte_w;
      spi_miso_oe_r <= st_rd_w;
    end else if (sclk_fall_w && bit_cnt_r >= `FESR_OP_BITS) begin
      spi_miso_r <= tx_r[7];
      tx_r <= {tx_r[6:0], tx_r[7]};
    end
  end

  // ----------------------------------------------------------------
  // Command classification
  // ----------------------------------------------------------------
  fesr_cls_if cls_if ();
  assign cls_if.opcode = opcode_r;
  fesr_cmd_class u_cls (
    .cls_if(cls_if)
  );

  // ----------------------------------------------------------------
  // Suspend state
  // ----------------------------------------------------------------
  fesr_pkg::fesr_state_t state_r;
  fesr_pkg::fesr_state_t state_nxt;
  logic [15:0] lat_cnt_r;
  logic sus_r;
  logic wel_r;
  logic resume_pend_r;
  logic [23:0] susp_base_r;
  fesr_pkg::fesr_esize_t susp_size_r;

  // Addressed commands are judged when the address is complete, others when the frame ends
  wire decide_w = cls_if.needs_addr ? addr_done_w : (cs_rise_w & (bit_cnt_r >= `FESR_OP_BITS));
  wire in_run_w = (state_r == fesr_pkg::FESR_ST_RUN);
  wire in_lat_w = (state_r == fesr_pkg::FESR_ST_LAT);
  wire in_susp_w = (state_r == fesr_pkg::FESR_ST_SUSP);
  wire hit_w = cls_if.needs_addr & region_hit(addr_w, susp_base_r, susp_size_r);
  wire wip_w = core_erase_busy | core_prog_busy | core_wrsr_busy | resume_pend_r;
  wire lat_done_w = in_lat_w & (lat_cnt_r == 16'h0000);
  wire accept_w = in_run_w | (cls_if.cls == fesr_pkg::FESR_CL_ANY) |
                  (in_susp_w & (cls_if.cls == fesr_pkg::FESR_CL_AFTER) & ~hit_w);
  wire suspend_go_w = decide_w & cls_if.is_suspend & in_run_w &
                      core_erase_busy & ~core_wrsr_busy;
  // A suspended erase stays parked until the host resumes it
  wire resume_go_w = decide_w & cls_if.is_resume & in_susp_w & sus_r & ~wip_w;
  wire grant_go_w = decide_w & accept_w & ~cls_if.is_suspend & ~cls_if.is_resume;
  wire wren_w = grant_go_w & (opcode_r == `FESR_OP_WREN);
  wire wrdi_w = grant_go_w & (opcode_r == `FESR_OP_WRDI);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      fesr_pkg::FESR_ST_RUN: if (suspend_go_w) state_nxt = fesr_pkg::FESR_ST_LAT;
      fesr_pkg::FESR_ST_LAT: if (lat_done_w) state_nxt = fesr_pkg::FESR_ST_SUSP;
      fesr_pkg::FESR_ST_SUSP: if (resume_go_w) state_nxt = fesr_pkg::FESR_ST_RUN;
      default: state_nxt = fesr_pkg::FESR_ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_r <= fesr_pkg::FESR_ST_RUN;
      lat_cnt_r <= 16'h0000;
      erase_hold_r <= 1'b0;
      susp_base_r <= 24'h000000;
      susp_size_r <= fesr_pkg::FESR_ES_4K;
    end else begin
      state_r <= state_nxt;
      if (suspend_go_w) begin
        lat_cnt_r <= SUSP_LAT_LD;
        erase_hold_r <= 1'b1;
        susp_base_r <= core_erase_addr;
        susp_size_r <= fesr_pkg::fesr_esize_t'(core_erase_size);
      end else if (in_lat_w && !lat_done_w) begin
        lat_cnt_r <= lat_cnt_r - 16'h0001;
      end
      if (resume_go_w) begin
        erase_hold_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sus_r <= 1'b0;
      wel_r <= 1'b0;
      resume_pend_r <= 1'b0;
    end else begin
      if (lat_done_w) begin
        sus_r <= 1'b1;
      end else if (resume_go_w) begin
        sus_r <= 1'b0;
      end
      if (lat_done_w || core_wel_clr || wrdi_w) begin
        wel_r <= 1'b0;
      end else if (wren_w) begin
        wel_r <= 1'b1;
      end
      // Holds write in progress high until the core picks the erase up again
      if (resume_go_w) begin
        resume_pend_r <= 1'b1;
      end else if (core_erase_busy) begin
        resume_pend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the core
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      grant_valid_r <= 1'b0;
      grant_opcode_r <= 8'h00;
      grant_addr_r <= 24'h000000;
      ignored_r <= 1'b0;
      status_word_r <= `FESR_STATUS_RST;
    end else begin
      grant_valid_r <= grant_go_w;
      ignored_r <= decide_w & ~grant_go_w & ~suspend_go_w & ~resume_go_w;
      if (grant_go_w) begin
        grant_opcode_r <= opcode_r;
        grant_addr_r <= cls_if.needs_addr ? addr_w : 24'h000000;
      end
      status_word_r <= {sus_r, 13'h0000, wel_r, wip_w};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  region_block_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    decide_w && in_susp_w && hit_w |=> !grant_valid_r && ignored_r)
    else $error("command into suspended region was granted");
  lat_load_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    suspend_go_w |=> in_lat_w && lat_cnt_r == SUSP_LAT_LD && erase_hold_r && !sus_r)
    else $error("suspend did not start the latency");
  lat_end_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    lat_done_w |=> sus_r && !wel_r && in_susp_w)
    else $error("latency end did not set suspend and clear latch");
  lat_block_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    decide_w && in_lat_w && cls_if.cls != fesr_pkg::FESR_CL_ANY |=> !grant_valid_r)
    else $error("command granted during suspend latency");
  after_grant_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    decide_w && in_susp_w && cls_if.cls == fesr_pkg::FESR_CL_AFTER && !hit_w &&
    !cls_if.is_resume |=> grant_valid_r && grant_opcode_r == $past(opcode_r))
    else $error("allowed command refused during suspend");
  anytime_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    decide_w && cls_if.cls == fesr_pkg::FESR_CL_ANY |=> grant_valid_r)
    else $error("status or reset command refused");
  sus_bit_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(sus_r) |=> status_word_r[`FESR_SB_SUS] ##1 status_word_r[`FESR_SB_SUS] == sus_r)
    else $error("status word does not show suspend flag");
  resume_ok_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    resume_go_w |=> !sus_r && !erase_hold_r ##[0:RES_WIP_LIM] status_word_r[`FESR_SB_WIP])
    else $error("resume did not clear suspend or raise write in progress");
  resume_ign_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    decide_w && cls_if.is_resume && !in_lat_w && (!sus_r || wip_w) |=>
    $stable(sus_r) && $stable(erase_hold_r) && ignored_r)
    else $error("resume acted while it should be ignored");
  wrsr_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    decide_w && cls_if.is_suspend && core_wrsr_busy |=> $stable(state_r) && $stable(erase_hold_r))
    else $error("status register write was suspended");
  no_erase_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    decide_w && cls_if.is_suspend && !core_erase_busy && !core_wel_clr |=>
    $stable(sus_r) && $stable(wel_r) && $stable(erase_hold_r))
    else $error("suspend without erase changed state");
endmodule

// ==== pkg/fesr_params.svh ====
// Constants for the erase suspend and resume sequencer
// Summary of operation
// - While suspended, reads and programs hit everything except the suspended erase region.
// - After suspend, wait the latency, clear write enable latch, set suspended flag.
// - After the latency, array read commands are accepted during suspend.
// - After the latency, page program and quad page program are accepted outside region.
// - After the latency, identification, unique number, security and parameter reads accepted.
// - After the latency, write enable, write disable, wrap setting and resume accepted.
// - Status reads and reset commands are accepted any time, latency does not apply.
// - The erase suspended flag is bit 15 of the status word.
// - Suspended flag sets when erase suspends, clears when erase resumes.
// - Resume is accepted only with suspended flag 1 and write in progress 0.
// - Resume with suspended flag 0 or write in progress 1 is discarded.
// - Accepted resume clears suspended flag at once, write in progress within 200 ns.
// - Suspend interrupts only a sector, 32KB or 64KB block erase.
// - A status register write is never suspended.
`ifndef FESR_PARAMS_SVH
`define FESR_PARAMS_SVH
// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define FESR_OP_WREN 8'h06
`define FESR_OP_WRDI 8'h04
`define FESR_OP_READ 8'h03
`define FESR_OP_FREAD 8'h0b
`define FESR_OP_DOREAD 8'h3b
`define FESR_OP_QOREAD 8'h6b
`define FESR_OP_DIOREAD 8'hbb
`define FESR_OP_QIOREAD 8'heb
`define FESR_OP_QWREAD 8'he7
`define FESR_OP_WRAP 8'h77
`define FESR_OP_MDID 8'h90
`define FESR_OP_DMDID 8'h92
`define FESR_OP_QMDID 8'h94
`define FESR_OP_JEDID 8'h9f
`define FESR_OP_UID 8'h4b
`define FESR_OP_RELPD 8'hab
`define FESR_OP_SECRD 8'h48
`define FESR_OP_PARRD 8'h5a
`define FESR_OP_PP 8'h02
`define FESR_OP_QPP 8'h32
`define FESR_OP_RESUME 8'h7a
`define FESR_OP_SUSPEND 8'h75
`define FESR_OP_RDSR1 8'h05
`define FESR_OP_RDSR2 8'h35
`define FESR_OP_RDSR3 8'h15
`define FESR_OP_RSTEN 8'h66
`define FESR_OP_RST 8'h99
// ----------------------------------------------------------------
// Status word fields and frame counts
// ----------------------------------------------------------------
`define FESR_SB_WIP 0
`define FESR_SB_WEL 1
`define FESR_SB_SUS 15
`define FESR_STATUS_RST 16'h0000
`define FESR_OP_BITS 6'h08
`define FESR_ADDR_END 6'h20
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FESR_CLK_MHZ 20
`define FESR_SUSP_LAT_NS 20000
`define FESR_RES_WIP_NS 200
`endif

// ==== pkg/fesr_pkg.sv ====
// Types for the erase suspend and resume sequencer
package fesr_pkg;
  typedef enum logic [1:0] {
    FESR_ST_RUN = 2'h0,
    FESR_ST_LAT = 2'h1,
    FESR_ST_SUSP = 2'h3
  } fesr_state_t;
  typedef enum logic [1:0] {
    FESR_ES_4K = 2'h0,
    FESR_ES_32K = 2'h1,
    FESR_ES_64K = 2'h2
  } fesr_esize_t;
  typedef enum logic [1:0] {
    FESR_CL_NONE = 2'h0,
    FESR_CL_ANY = 2'h1,
    FESR_CL_AFTER = 2'h2
  } fesr_cls_t;
endpackage

// ==== pkg/fesr_cls_if.sv ====
// Opcode classification link between the sequencer and its decoder
`timescale 1ns/1ps
interface fesr_cls_if;
  logic [7:0] opcode;
  fesr_pkg::fesr_cls_t cls;
  logic needs_addr;
  logic is_suspend;
  logic is_resume;
  modport dec (input opcode, output cls, needs_addr, is_suspend, is_resume);
  modport use_side (output opcode, input cls, needs_addr, is_suspend, is_resume);
endinterface

// ==== design/fesr_cmd_class.sv ====
// Opcode classifier for commands seen during an erase suspend
`timescale 1ns/1ps
`include "fesr_params.svh"
module fesr_cmd_class (
  fesr_cls_if.dec cls_if
);
  wire [7:0] op = cls_if.opcode;
  // ----------------------------------------------------------------
  // Commands that ignore the suspend latency
  // ----------------------------------------------------------------
  wire any_w = (op == `FESR_OP_RDSR1) || (op == `FESR_OP_RDSR2) || (op == `FESR_OP_RDSR3) ||
               (op == `FESR_OP_RSTEN) || (op == `FESR_OP_RST);
  // ----------------------------------------------------------------
  // Commands allowed once the latency is over
  // ----------------------------------------------------------------
  wire rd_w = (op == `FESR_OP_READ) || (op == `FESR_OP_FREAD) || (op == `FESR_OP_DOREAD) ||
              (op == `FESR_OP_QOREAD) || (op == `FESR_OP_DIOREAD) || (op == `FESR_OP_QIOREAD) ||
              (op == `FESR_OP_QWREAD);
  wire pp_w = (op == `FESR_OP_PP) || (op == `FESR_OP_QPP);
  wire id_w = (op == `FESR_OP_MDID) || (op == `FESR_OP_DMDID) || (op == `FESR_OP_QMDID) ||
              (op == `FESR_OP_JEDID) || (op == `FESR_OP_UID) || (op == `FESR_OP_RELPD) ||
              (op == `FESR_OP_SECRD) || (op == `FESR_OP_PARRD);
  wire ctl_w = (op == `FESR_OP_WREN) || (op == `FESR_OP_WRDI) || (op == `FESR_OP_WRAP) ||
               (op == `FESR_OP_RESUME);
  wire after_w = rd_w || pp_w || id_w || ctl_w;
  assign cls_if.cls = any_w ? fesr_pkg::FESR_CL_ANY :
                      after_w ? fesr_pkg::FESR_CL_AFTER : fesr_pkg::FESR_CL_NONE;
  // Only array reads and programs carry an address that must be checked against the region
  assign cls_if.needs_addr = rd_w || pp_w;
  assign cls_if.is_suspend = (op == `FESR_OP_SUSPEND);
  assign cls_if.is_resume = (op == `FESR_OP_RESUME);
endmodule

// ==== verification/fesr_host_model.sv ====
// SPI host model that frames commands for the erase suspend sequencer
`timescale 1ns/1ps
module fesr_host_model (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  localparam int HALF_NS = 200;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // ----------------------------------------------------------------
  // Mode 0 frame, MSB first; clock stands low outside frames
  // ----------------------------------------------------------------
  task automatic frame(input logic [31:0] bits, input int nbits, input int nrd,
                       output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0;
    #(HALF_NS);
    for (int i = 0; i < nbits + nrd; i++) begin
      mosi = (i < nbits) ? bits[31 - i] : ~mosi;
      #(HALF_NS);
      sclk = 1'b1;
      if (i >= nbits) begin
        rd = {rd[6:0], (miso_oe === 1'b1) ? miso : 1'bx};
      end
      #(HALF_NS);
      sclk = 1'b0;
    end
    #(HALF_NS);
    cs_n = 1'b1;
    // Released line toggles so a stale level never passes for data
    mosi = ~mosi;
    #(HALF_NS);
  endtask
endmodule

// ==== verification/tb_flash_erase_suspend_resume.sv ====
// Self-checking bench for the erase suspend and resume sequencer
`timescale 1ns/1ps
`include "fesr_params.svh"
module tb_flash_erase_suspend_resume;
  // Shortened latency keeps the run small; expectations derive from it
  localparam int LAT_NS = 16000;
  localparam int LAT_CYC = LAT_NS / 50;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso_r, spi_miso_oe_r;
  logic core_erase_busy = 1'b0;
  logic core_prog_busy = 1'b0;
  logic core_wrsr_busy = 1'b0;
  logic core_wel_clr = 1'b0;
  logic erase_job = 1'b0;
  logic [1:0] core_erase_size = 2'h0;
  logic [23:0] core_erase_addr = 24'h000000;
  logic grant_valid_r, ignored_r, erase_hold_r, hold_q, sus_q, wip_q;
  logic [7:0] grant_opcode_r, rd;
  logic [23:0] grant_addr_r;
  logic [15:0] status_word_r;
  int errors = 0;
  int checked = 0;
  int n_grant = 0;
  int n_ign = 0;
  int cyc = 0;
  int t_hold, t_sus, t_sfall, t_wip;
  always #25 ref_clk = ~ref_clk;
  fesr_top #(.SUSP_LAT_NS(LAT_NS)) u_dut (.ref_clk(ref_clk), .rstn(rstn),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .core_erase_busy(core_erase_busy), .core_prog_busy(core_prog_busy),
    .core_wrsr_busy(core_wrsr_busy), .core_wel_clr(core_wel_clr),
    .core_erase_size(core_erase_size), .core_erase_addr(core_erase_addr),
    .spi_miso_r(spi_miso_r), .spi_miso_oe_r(spi_miso_oe_r), .grant_valid_r(grant_valid_r),
    .grant_opcode_r(grant_opcode_r), .grant_addr_r(grant_addr_r), .ignored_r(ignored_r),
    .erase_hold_r(erase_hold_r), .status_word_r(status_word_r));
  fesr_host_model u_host (.sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi),
    .miso(spi_miso_r), .miso_oe(spi_miso_oe_r));
  // ----------------------------------------------------------------
  // Pulse counters, edge times and a simple erase core
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    if (grant_valid_r === 1'b1) n_grant++;
    if (ignored_r === 1'b1) n_ign++;
    if (erase_hold_r === 1'b1 && hold_q !== 1'b1) t_hold = cyc;
    if (status_word_r[15] === 1'b1 && sus_q !== 1'b1) t_sus = cyc;
    if (status_word_r[15] === 1'b0 && sus_q === 1'b1) t_sfall = cyc;
    if (status_word_r[0] === 1'b1 && wip_q !== 1'b1) t_wip = cyc;
    hold_q = erase_hold_r;
    sus_q = status_word_r[15];
    wip_q = status_word_r[0];
    // Core pauses its erase while held
    core_erase_busy <= #1 erase_job & ~erase_hold_r;
  end
  task automatic chk(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // Expect: 0 nothing, 1 grant, 2 ignored
  task automatic cmd(input logic [7:0] op, input logic [23:0] addr, input int ex);
    int g0, i0;
    bit adr;
    g0 = n_grant;
    i0 = n_ign;
    adr = op inside {8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'he7, 8'h02, 8'h32};
    u_host.frame({op, adr ? addr : 24'h000000}, adr ? 32 : 8, 0, rd);
    repeat (8) @(posedge ref_clk);
    #1;
    chk((n_grant - g0) == (ex == 1) && (n_ign - i0) == (ex == 2), $sformatf("op %h", op));
    if (ex == 1) begin
      chk(grant_opcode_r === op && grant_addr_r === (adr ? addr : 24'h000000), "grant");
    end
  endtask
  task automatic sread(input logic [7:0] op, input logic [7:0] exp_byte);
    u_host.frame({op, 24'h000000}, 8, 8, rd);
    repeat (8) @(posedge ref_clk);
    #1;
    chk(rd === exp_byte, $sformatf("status %h read %h", op, rd));
  endtask
  task automatic wait_sus();
    for (int i = 0; i < 2 * LAT_CYC && status_word_r[15] !== 1'b1; i++) @(posedge ref_clk);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_run();
    chk(status_word_r === 16'h0000 && erase_hold_r === 1'b0, "reset values");
    cmd(`FESR_OP_RESUME, 24'h0, 2);
    cmd(`FESR_OP_SUSPEND, 24'h0, 2);
    chk(status_word_r === 16'h0000 && erase_hold_r === 1'b0, "idle suspend");
    cmd(`FESR_OP_WREN, 24'h0, 1);
    chk(status_word_r === 16'h0002, "wel set");
    @(posedge ref_clk) core_wel_clr <= #1 1'b1;
    @(posedge ref_clk) core_wel_clr <= #1 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(status_word_r[1] === 1'b0, "wel cleared by core");
    cmd(`FESR_OP_WREN, 24'h0, 1);
    erase_job = 1'b1;
    core_wrsr_busy = 1'b1;
    cmd(`FESR_OP_SUSPEND, 24'h0, 2);
    chk(erase_hold_r === 1'b0, "wrsr not held");
    core_wrsr_busy = 1'b0;
    sread(`FESR_OP_RDSR1, 8'h03);
    $display("test run done");
  endtask
  task automatic t_suspend();
    core_erase_size = 2'h0;
    core_erase_addr = 24'h012345;
    cmd(`FESR_OP_SUSPEND, 24'h0, 0);
    chk(erase_hold_r === 1'b1, "hold");
    cmd(`FESR_OP_WREN, 24'h0, 2);
    sread(`FESR_OP_RDSR1, 8'h02);
    wait_sus();
    chk(t_sus - t_hold == LAT_CYC + 1, "latency length");
    chk(status_word_r === 16'h8000, "suspended status");
    sread(`FESR_OP_RDSR2, 8'h80);
    $display("test suspend done");
  endtask
  task automatic t_allowed();
    logic [7:0] ops [16] = '{8'h06, 8'h04, 8'h77, 8'h90, 8'h92, 8'h94, 8'h9f, 8'h4b,
                             8'hab, 8'h48, 8'h5a, 8'h05, 8'h35, 8'h15, 8'h66, 8'h99};
    logic [7:0] aops [9] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'he7, 8'h02, 8'h32};
    foreach (ops[i]) cmd(ops[i], 24'h0, 1);
    foreach (aops[i]) begin
      cmd(aops[i], 24'h013000, 1);
      cmd(aops[i], 24'h012fff, 2);
    end
    cmd(8'h20, 24'h0, 2);
    cmd(`FESR_OP_SUSPEND, 24'h0, 2);
    $display("test allowed done");
  endtask
  task automatic t_resume();
    core_prog_busy = 1'b1;
    cmd(`FESR_OP_RESUME, 24'h0, 2);
    chk(erase_hold_r === 1'b1 && status_word_r[15] === 1'b1, "still suspended");
    core_prog_busy = 1'b0;
    repeat (3) @(posedge ref_clk);
    cmd(`FESR_OP_RESUME, 24'h0, 0);
    chk(erase_hold_r === 1'b0 && status_word_r[15] === 1'b0, "resumed");
    chk(t_wip >= t_sfall && t_wip - t_sfall <= 4, "wip after resume");
    chk(core_erase_busy === 1'b1 && status_word_r[0] === 1'b1, "erase continues");
    $display("test resume done");
  endtask
  task automatic t_sizes();
    int sz;
    // Size code 3 is not a legal erase size; it must guard a 64KB block
    for (int s = 0; s < 4; s++) begin
      sz = (s == 0) ? 4096 : (s == 1) ? 32768 : 65536;
      core_erase_size = s[1:0];
      core_erase_addr = 24'h240123;
      cmd(`FESR_OP_SUSPEND, 24'h0, 0);
      wait_sus();
      cmd(8'h03, 24'h240000 + sz[23:0] - 24'h1, 2);
      cmd(8'h03, 24'h240000 + sz[23:0], 1);
      cmd(8'h03, 24'h23ffff, 1);
      cmd(`FESR_OP_RESUME, 24'h0, 0);
      chk(status_word_r[15] === 1'b0, "size resume");
    end
    $display("test sizes done");
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    t_run();
    t_suspend();
    t_allowed();
    t_resume();
    t_sizes();
    test_done();
  end
  initial begin
    #4ms;
    errors++;
    test_done();
  end
endmodule
